// *** sihw_decoder.sv ***
// Serial command decoder with soft unlock, module label and host watchdog
//
// Function
// - Unlock command arms soft unlock, acknowledges
// - Bad syntax, error or other address: silent
// - Reply opens with ! or ?, address
// - Store label up to six characters
// - Unlock window in seconds, max 60
// - Unlock then configuration, within window
// - Zero window refuses unlock with ?
// - Window resets to zero
// - Host-alive broadcast never gets reply
// - Status bit7 enabled, bit2 timeout
// - Timeout flag survives reset, clear command only
// - Clear command zeroes flag, acknowledges
// - Timeout read gives enable digit, value
// - Timeout value counts tenths of second
// - One command sets enable and value
// - Set command: digit 3, enable, value
// - Timeout disables the watchdog
`timescale 1ns/1ns
module sihw_decoder
	import sihw_pkg::*;
#(
	parameter int TICK_CYCLES_P = TICK_CYCLES
) (
	input wire logic core_clk_in,
	input wire logic reset_in,
	input wire logic [7:0] rx_data_in,
	input wire logic rx_valid_in,
	input wire logic rx_error_in,
	output logic [7:0] tx_data_out,
	output logic tx_valid_out,
	input wire logic tx_ready_in,
	input wire logic nv_flag_in,
	output logic nv_flag_out,
	output logic config_apply_out,
	output logic [31:0] config_data_out,
	input wire logic hsel_in,
	input wire logic [31:0] haddr_in,
	input wire logic [1:0] htrans_in,
	input wire logic hwrite_in,
	input wire logic [2:0] hsize_in,
	input wire logic [31:0] hwdata_in,
	input wire logic hready_in,
	output logic hreadyout_out,
	output logic hresp_out,
	output logic [31:0] hrdata_out
);
	function automatic logic [4:0] hex_val(input logic [7:0] c);
		if (c >= 8'h30 && c <= 8'h39) return {1'b1, c[3:0]};
		if ((c >= 8'h41 && c <= 8'h46) || (c >= 8'h61 && c <= 8'h66)) return {1'b1, c[3:0] + 4'h9};
		return 5'h00;
	endfunction
	function automatic logic [7:0] hex_char(input logic [3:0] v);
		return (v < 4'hA) ? 8'h30 + {4'h0, v} : 8'h37 + {4'h0, v};
	endfunction
	logic [7:0] rx_buf_ff [RX_DEPTH];
	logic [4:0] rx_len_ff;
	logic [7:0] tx_buf_ff [TX_DEPTH];
	logic [3:0] tx_left_ff;
	sihw_state_t state_ff;
	logic [7:0] addr_ff, window_ff, wd_tenths_ff, wd_cnt_ff, wr_addr_ff;
	logic chk_en_ff, init_pin_ff, unlock_ff, wd_en_ff, wd_flag_ff, load_pend_ff;
	logic rx_bad_ff, cfg_apply_ff, wr_pend_ff;
	logic [11:0] unlock_cnt_ff;
	logic [31:0] tick_cnt_ff, cfg_data_ff, hrdata_ff;
	logic [7:0] name_ff [NAME_MAX];
	logic [2:0] name_len_ff;

	// Frame framing and decode
	wire frame_done = rx_valid_in && rx_data_in == CH_CR;
	wire [4:0] body_len = chk_en_ff ? rx_len_ff - 5'h02 : rx_len_ff;
	wire len_ok = !chk_en_ff || rx_len_ff >= 5'h02;
	logic [7:0] sum_rx;
	logic [31:0] cfg_word;
	logic cfg_hex_ok;
	logic [4:0] chk_hi, chk_lo, cfg_nib;
	always_comb begin
		sum_rx = 8'h00;
		cfg_word = 32'h0000_0000;
		cfg_hex_ok = 1'b1;
		cfg_nib = 5'h00;
		for (int i = 0; i < RX_DEPTH; i++) if (5'(i) < body_len) sum_rx = sum_rx + rx_buf_ff[i];
		for (int i = 0; i < 8; i++) begin
			cfg_nib = hex_val(rx_buf_ff[3 + i]);
			cfg_word = {cfg_word[27:0], cfg_nib[3:0]};
			cfg_hex_ok = cfg_hex_ok && cfg_nib[4];
		end
		chk_hi = hex_val(rx_buf_ff[4'(body_len)]);
		chk_lo = hex_val(rx_buf_ff[4'(body_len + 5'h01)]);
	end
	wire chk_ok = !chk_en_ff || (chk_hi[4] && chk_lo[4] && {chk_hi[3:0], chk_lo[3:0]} == sum_rx);
	wire frame_ok = frame_done && !rx_bad_ff && !rx_error_in && len_ok && chk_ok &&
		state_ff == SIHW_IDLE;
	wire [4:0] a_hi = hex_val(rx_buf_ff[1]);
	wire [4:0] a_lo = hex_val(rx_buf_ff[2]);
	wire addr_hit = frame_ok && a_hi[4] && a_lo[4] && {a_hi[3:0], a_lo[3:0]} == addr_ff;
	wire tilde_hit = addr_hit && rx_buf_ff[0] == CH_TILDE;
	wire [4:0] v_hi = hex_val(rx_buf_ff[4]);
	wire [4:0] v_lo = hex_val(rx_buf_ff[5]);
	wire [4:0] e_hi = hex_val(rx_buf_ff[5]);
	wire [4:0] e_lo = hex_val(rx_buf_ff[6]);
	wire is_alive = frame_ok && rx_buf_ff[0] == CH_TILDE && rx_buf_ff[1] == CH_STAR &&
		rx_buf_ff[2] == CH_STAR && body_len == LEN_ALIVE;
	wire cmd_unlock = tilde_hit && rx_buf_ff[3] == CH_I && body_len == LEN_SHORT;
	wire cmd_name = tilde_hit && rx_buf_ff[3] == CH_O && body_len > LEN_SHORT &&
		body_len <= LEN_NAME_MAX;
	wire cmd_window = tilde_hit && rx_buf_ff[3] == CH_T && body_len == LEN_WINDOW &&
		v_hi[4] && v_lo[4];
	wire cmd_status = tilde_hit && rx_buf_ff[3] == CH_0 && body_len == LEN_SHORT;
	wire cmd_clear = tilde_hit && rx_buf_ff[3] == CH_1 && body_len == LEN_SHORT;
	wire cmd_rdwd = tilde_hit && rx_buf_ff[3] == CH_2 && body_len == LEN_SHORT;
	wire cmd_setwd = tilde_hit && rx_buf_ff[3] == CH_3 && body_len == LEN_SETWD &&
		(rx_buf_ff[4] == CH_0 || rx_buf_ff[4] == CH_1) && e_hi[4] && e_lo[4];
	wire cmd_config = addr_hit && rx_buf_ff[0] == CH_PCT && body_len == LEN_CONFIG && cfg_hex_ok;
	wire cmd_rdname = addr_hit && rx_buf_ff[0] == CH_DOLLAR && rx_buf_ff[3] == CH_M &&
		body_len == LEN_SHORT;
	wire any_cmd = cmd_unlock || cmd_name || cmd_window || cmd_status || cmd_clear ||
		cmd_rdwd || cmd_setwd || cmd_config || cmd_rdname;
	wire [7:0] new_window = {v_hi[3:0], v_lo[3:0]};
	wire [7:0] new_tenths = {e_hi[3:0], e_lo[3:0]};
	// A zero window makes the unlock meaningless, so it is refused
	wire unlock_ok = window_ff != WINDOW_RESET;
	wire config_ok = init_pin_ff || unlock_ff;
	wire reply_ok = !((cmd_unlock && !unlock_ok) || (cmd_window && new_window > WINDOW_MAX_S) ||
		(cmd_config && !config_ok));
	wire [7:0] wd_status = {wd_en_ff, 4'h0, wd_flag_ff, 2'b00};
	// Reply assembly: body, optional checksum, CR
	logic [7:0] nxt_tx [TX_DEPTH];
	logic [3:0] nxt_len;
	logic [7:0] sum_tx;
	always_comb begin
		sum_tx = 8'h00;
		for (int i = 0; i < TX_DEPTH; i++) nxt_tx[i] = 8'h00;
		nxt_tx[0] = reply_ok ? CH_BANG : CH_QMARK;
		nxt_tx[1] = hex_char(addr_ff[7:4]);
		nxt_tx[2] = hex_char(addr_ff[3:0]);
		nxt_len = 4'h3;
		if (reply_ok && cmd_status) begin
			nxt_tx[3] = hex_char(wd_status[7:4]);
			nxt_tx[4] = hex_char(wd_status[3:0]);
			nxt_len = 4'h5;
		end else if (reply_ok && cmd_rdwd) begin
			nxt_tx[3] = wd_en_ff ? CH_1 : CH_0;
			nxt_tx[4] = hex_char(wd_tenths_ff[7:4]);
			nxt_tx[5] = hex_char(wd_tenths_ff[3:0]);
			nxt_len = 4'h6;
		end else if (reply_ok && cmd_rdname) begin
			for (int i = 0; i < NAME_MAX; i++) begin
				if (3'(i) < name_len_ff) nxt_tx[3 + i] = name_ff[i];
			end
			nxt_len = 4'h3 + {1'b0, name_len_ff};
		end
		for (int i = 0; i < TX_DEPTH; i++) if (4'(i) < nxt_len) sum_tx = sum_tx + nxt_tx[i];
		if (chk_en_ff) begin
			nxt_tx[nxt_len] = hex_char(sum_tx[7:4]);
			nxt_tx[nxt_len + 4'h1] = hex_char(sum_tx[3:0]);
			nxt_len = nxt_len + 4'h2;
		end
		nxt_tx[nxt_len] = CH_CR;
		nxt_len = nxt_len + 4'h1;
	end
	// Receive buffer; overflow spoils the frame rather than wrapping
	always_ff @(posedge core_clk_in) begin
		if (reset_in || frame_done) begin
			rx_len_ff <= 5'h00;
			rx_bad_ff <= 1'b0;
		end else if (rx_valid_in) begin
			if (rx_len_ff == 5'(RX_DEPTH)) rx_bad_ff <= 1'b1;
			else rx_len_ff <= rx_len_ff + 5'h01;
			if (rx_error_in) rx_bad_ff <= 1'b1;
		end else if (rx_error_in) begin
			rx_bad_ff <= 1'b1;
		end
	end
	always_ff @(posedge core_clk_in) begin
		if (rx_valid_in && !frame_done && rx_len_ff < 5'(RX_DEPTH)) rx_buf_ff[4'(rx_len_ff)] <= rx_data_in;
	end
	// Transmit shifter: head byte drives the output
	wire tx_shift = state_ff == SIHW_SEND && tx_ready_in;
	wire reply_go = any_cmd;
	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			state_ff <= SIHW_IDLE;
			tx_left_ff <= 4'h0;
		end else begin
			case (state_ff)
				SIHW_IDLE: begin
					if (reply_go) begin
						state_ff <= SIHW_SEND;
						tx_left_ff <= nxt_len;
					end
				end
				SIHW_SEND: begin
					if (tx_ready_in) begin
						tx_left_ff <= tx_left_ff - 4'h1;
						if (tx_left_ff == 4'h1) state_ff <= SIHW_IDLE;
					end
				end
				default: state_ff <= SIHW_IDLE;
			endcase
		end
	end
	generate
		for (genvar g = 0; g < TX_DEPTH; g++) begin : g_tx
			always_ff @(posedge core_clk_in) begin
				if (reset_in) tx_buf_ff[g] <= 8'h00;
				else if (reply_go) tx_buf_ff[g] <= nxt_tx[g];
				else if (tx_shift) tx_buf_ff[g] <= (g == TX_DEPTH - 1) ? 8'h00 : tx_buf_ff[(g + 1) % TX_DEPTH];
			end
		end
	endgenerate
	assign tx_valid_out = state_ff == SIHW_SEND;
	assign tx_data_out = tx_buf_ff[0];
	// Tenth-second tick shared by both timers
	wire tick = tick_cnt_ff == 32'(TICK_CYCLES_P - 1);
	always_ff @(posedge core_clk_in) begin
		if (reset_in || tick) tick_cnt_ff <= 32'h0000_0000;
		else tick_cnt_ff <= tick_cnt_ff + 32'h0000_0001;
	end
	// Soft unlock and its window
	wire [11:0] window_tenths = 12'({4'h0, window_ff} * TENTHS_PER_S);
	wire unlock_expire = unlock_ff && tick && unlock_cnt_ff + 12'h001 >= window_tenths;
	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			window_ff <= WINDOW_RESET;
			unlock_ff <= 1'b0;
			unlock_cnt_ff <= 12'h000;
		end else begin
			if (cmd_window && new_window <= WINDOW_MAX_S) window_ff <= new_window;
			if (cmd_unlock && unlock_ok) begin
				unlock_ff <= 1'b1;
				unlock_cnt_ff <= 12'h000;
			end else if (any_cmd || unlock_expire) begin
				unlock_ff <= 1'b0;
			end else if (unlock_ff && tick) begin
				unlock_cnt_ff <= unlock_cnt_ff + 12'h001;
			end
		end
	end
	// Host watchdog; the flag is reloaded from outside storage after reset
	wire wd_expire = wd_en_ff && tick && !is_alive && !cmd_setwd &&
		{1'b0, wd_cnt_ff} + 9'h001 >= {1'b0, wd_tenths_ff};
	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			wd_en_ff <= 1'b0;
			wd_tenths_ff <= 8'h00;
			wd_cnt_ff <= 8'h00;
			wd_flag_ff <= 1'b0;
			load_pend_ff <= 1'b1;
		end else begin
			load_pend_ff <= 1'b0;
			if (cmd_setwd) begin
				wd_en_ff <= rx_buf_ff[4] == CH_1;
				wd_tenths_ff <= new_tenths;
			end else if (wd_expire) begin
				wd_en_ff <= 1'b0;
			end
			if (is_alive || cmd_setwd) wd_cnt_ff <= 8'h00;
			else if (wd_en_ff && tick) wd_cnt_ff <= wd_cnt_ff + 8'h01;
			if (load_pend_ff) wd_flag_ff <= nv_flag_in;
			else if (wd_expire) wd_flag_ff <= 1'b1;
			else if (cmd_clear) wd_flag_ff <= 1'b0;
		end
	end
	assign nv_flag_out = wd_flag_ff;
	// Label storage and configuration handoff
	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			name_len_ff <= 3'h0;
			cfg_apply_ff <= 1'b0;
			cfg_data_ff <= 32'h0000_0000;
		end else begin
			cfg_apply_ff <= cmd_config && config_ok;
			if (cmd_config && config_ok) cfg_data_ff <= cfg_word;
			if (cmd_name) name_len_ff <= 3'(body_len - LEN_SHORT);
		end
	end
	generate
		for (genvar g = 0; g < NAME_MAX; g++) begin : g_name
			always_ff @(posedge core_clk_in) begin
				if (reset_in) name_ff[g] <= 8'h00;
				else if (cmd_name) name_ff[g] <= rx_buf_ff[4 + g];
			end
		end
	endgenerate
	assign config_apply_out = cfg_apply_ff;
	assign config_data_out = cfg_data_ff;
	// AHB-Lite slave, zero wait states, always OKAY
	wire ahb_take = hsel_in && htrans_in[1] && hready_in;
	wire [7:0] rd_sel = haddr_in[7:0];
	wire sel_ctrl = rd_sel == REG_CTRL;
	wire sel_stat = rd_sel == REG_STATUS;
	wire sel_cfg = rd_sel == REG_CONFIG;
	wire sel_nlo = rd_sel == REG_NAME_LO;
	wire sel_nhi = rd_sel == REG_NAME_HI;
	wire [31:0] ctrl_word = {22'h0, init_pin_ff, chk_en_ff, addr_ff};
	wire [31:0] stat_word = {8'h00, wd_tenths_ff, window_ff, 5'h00, wd_flag_ff, wd_en_ff, unlock_ff};
	wire [31:0] nlo_word = {name_ff[3], name_ff[2], name_ff[1], name_ff[0]};
	wire [31:0] nhi_word = {5'h00, name_len_ff, 8'h00, name_ff[5], name_ff[4]};
	wire [31:0] rd_word = sel_ctrl ? ctrl_word : sel_stat ? stat_word : sel_cfg ? cfg_data_ff :
		sel_nlo ? nlo_word : sel_nhi ? nhi_word : 32'h0000_0000;
	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			wr_pend_ff <= 1'b0;
			wr_addr_ff <= 8'h00;
			hrdata_ff <= 32'h0000_0000;
			addr_ff <= ADDR_RESET;
			chk_en_ff <= 1'b0;
			init_pin_ff <= 1'b0;
		end else begin
			wr_pend_ff <= ahb_take && hwrite_in;
			wr_addr_ff <= rd_sel;
			if (ahb_take && !hwrite_in) hrdata_ff <= rd_word;
			if (wr_pend_ff && wr_addr_ff == REG_CTRL) begin
				addr_ff <= hwdata_in[7:0];
				chk_en_ff <= hwdata_in[CTRL_CHK_BIT];
				init_pin_ff <= hwdata_in[CTRL_INIT_BIT];
			end
		end
	end
	assign hreadyout_out = 1'b1;
	assign hresp_out = 1'b0;
	assign hrdata_out = hrdata_ff;
	// Checks
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (reset_in);
	a_alive_silent: assert property (is_alive |=> !tx_valid_out)
		else $error("reply sent to host-alive broadcast");
	a_bad_silent: assert property (frame_done && state_ff == SIHW_IDLE && (rx_bad_ff || rx_error_in)
		|=> !tx_valid_out)
		else $error("reply sent to spoiled frame");
	a_reply_head: assert property (reply_go |=> tx_valid_out &&
		tx_data_out == ($past(reply_ok) ? CH_BANG : CH_QMARK) &&
		tx_buf_ff[1] == hex_char(addr_ff[7:4]))
		else $error("reply head wrong");
	a_unlock_arm: assert property (cmd_unlock && unlock_ok |=> unlock_ff ##1 unlock_ff)
		else $error("unlock not armed");
	a_config_refuse: assert property (cmd_config && !init_pin_ff && window_ff == WINDOW_RESET
		|=> tx_data_out == CH_QMARK && !cfg_apply_ff)
		else $error("config accepted with zero window");
	a_window_reset: assert property (disable iff (1'b0) reset_in |=> window_ff == WINDOW_RESET)
		else $error("window not zero after reset");
	a_status_digits: assert property (cmd_status |=> tx_buf_ff[3] == hex_char($past(wd_status[7:4]))
		&& tx_buf_ff[4] == hex_char($past(wd_status[3:0])))
		else $error("status digits wrong");
	a_flag_sticky: assert property (wd_flag_ff && !cmd_clear |=> wd_flag_ff)
		else $error("timeout flag lost");
	a_clear_flag: assert property (cmd_clear && !wd_expire |=> !wd_flag_ff && tx_data_out == CH_BANG)
		else $error("clear did not zero flag");
	a_set_load: assert property (cmd_setwd |=> wd_tenths_ff == $past(new_tenths)
		&& wd_en_ff == ($past(rx_buf_ff[4]) == CH_1))
		else $error("watchdog set not loaded");
	a_expire_off: assert property (wd_expire |=> !wd_en_ff && wd_flag_ff)
		else $error("expiry did not disable watchdog");
	a_alive_restart: assert property (is_alive |=> wd_cnt_ff == 8'h00)
		else $error("alive did not restart countdown");
	a_unlock_lapse: assert property (unlock_ff && any_cmd && !cmd_unlock |=> !unlock_ff)
		else $error("unlock survived another command");
	c_config_ok: cover property (cmd_config && config_ok);
	c_expire: cover property (wd_expire);
	c_name_read: cover property (cmd_rdname && name_len_ff != 3'h0);
	c_alive: cover property (is_alive && wd_en_ff);
endmodule // sihw_decoder

// *** sihw_pkg.sv ***
// Constants, characters, register map and types for the soft-unlock and host-watchdog decoder
package sihw_pkg;
	// Frame characters
	localparam logic [7:0] CH_TILDE = 8'h7E;
	localparam logic [7:0] CH_PCT = 8'h25;
	localparam logic [7:0] CH_DOLLAR = 8'h24;
	localparam logic [7:0] CH_STAR = 8'h2A;
	localparam logic [7:0] CH_CR = 8'h0D;
	localparam logic [7:0] CH_BANG = 8'h21;
	localparam logic [7:0] CH_QMARK = 8'h3F;
	localparam logic [7:0] CH_I = 8'h49;
	localparam logic [7:0] CH_O = 8'h4F;
	localparam logic [7:0] CH_T = 8'h54;
	localparam logic [7:0] CH_M = 8'h4D;
	localparam logic [7:0] CH_0 = 8'h30;
	localparam logic [7:0] CH_1 = 8'h31;
	localparam logic [7:0] CH_2 = 8'h32;
	localparam logic [7:0] CH_3 = 8'h33;
	// Buffer sizes and frame lengths (body, without checksum and CR)
	localparam int RX_DEPTH = 16;
	localparam int TX_DEPTH = 12;
	localparam int NAME_MAX = 6;
	localparam logic [4:0] LEN_SHORT = 5'h04;
	localparam logic [4:0] LEN_ALIVE = 5'h03;
	localparam logic [4:0] LEN_WINDOW = 5'h06;
	localparam logic [4:0] LEN_SETWD = 5'h07;
	localparam logic [4:0] LEN_CONFIG = 5'h0B;
	localparam logic [4:0] LEN_NAME_MAX = 5'h0A;
	// Reset values and limits
	localparam logic [7:0] WINDOW_RESET = 8'h00;
	localparam logic [7:0] WINDOW_MAX_S = 8'h3C;
	localparam logic [7:0] ADDR_RESET = 8'h01;
	localparam logic [11:0] TENTHS_PER_S = 12'h00A;
	// Timing: one watchdog tick is a tenth of a second
	localparam int CLK_PERIOD_NS = 50;
	localparam int TICK_NS = 100_000_000;
	localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
	// Register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_CONFIG = 8'h08;
	localparam logic [7:0] REG_NAME_LO = 8'h0C;
	localparam logic [7:0] REG_NAME_HI = 8'h10;
	// Field positions
	localparam int CTRL_CHK_BIT = 8;
	localparam int CTRL_INIT_BIT = 9;
	localparam int STAT_UNLOCK_BIT = 0;
	localparam int STAT_WDEN_BIT = 1;
	localparam int STAT_FLAG_BIT = 2;
	localparam int WDS_EN_BIT = 7;
	localparam int WDS_FLAG_BIT = 2;
	typedef enum logic {SIHW_IDLE, SIHW_SEND} sihw_state_t;
endpackage

// *** sihw_host_model.sv ***
// Host computer model on the serial command link
`timescale 1ns/1ns
module sihw_host_model (
	input wire logic clk_in,
	input wire logic [7:0] tx_data_in,
	input wire logic tx_valid_in,
	output logic [7:0] rx_data_out,
	output logic rx_valid_out,
	output logic rx_error_out,
	output logic tx_ready_out
);
	string got = "";
	bit slow = 1'b0;
	initial begin
		rx_data_out = 8'h00;
		rx_valid_out = 1'b0;
		rx_error_out = 1'b0;
		tx_ready_out = 1'b1;
	end
	// A slow host takes reply characters only every other cycle
	always @(posedge clk_in) begin
		if (tx_valid_in && tx_ready_out)
			got = {got, string'(tx_data_in)};
		tx_ready_out <= slow ? ~tx_ready_out : 1'b1;
	end
	// Whole frame, closed by CR; line carries inverted data between characters
	task automatic send(input string s, input bit err);
		byte c;
		got = "";
		for (int i = 0; i <= s.len(); i++) begin
			c = (i == s.len()) ? 8'h0D : s[i];
			@(posedge clk_in);
			rx_data_out <= c;
			rx_valid_out <= 1'b1;
			rx_error_out <= err;
			@(posedge clk_in);
			rx_valid_out <= 1'b0;
			rx_data_out <= ~c;
		end
		rx_error_out <= 1'b0;
	endtask
endmodule // sihw_host_model

// *** test_soft_init_host_watchdog_cmds.sv ***
// Self-checking bench for the soft-unlock and host-watchdog command decoder
`timescale 1ns/1ns
module test_soft_init_host_watchdog_cmds import sihw_pkg::*;;
	typedef struct {string cmd; string rep;} sihw_row_t;
	logic core_clk = 1'b0;
	logic reset = 1'b1;
	logic [7:0] rx_data;
	logic [7:0] tx_data;
	logic rx_valid, rx_error, tx_valid, tx_ready, nv_flag, config_apply, hreadyout, hresp;
	logic nv_store = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'b00;
	logic [31:0] haddr = 32'h00000000;
	logic [31:0] hwdata = 32'h00000000;
	logic [31:0] config_data, hrdata, rd;
	int mismatches = 0;
	int total_checks = 0;
	int applies = 0;
	sihw_row_t rows[$] = '{
		'{"~010", "!0100"},
		'{"~01I", "?01"},
		'{"%0101000700", "?01"},
		'{"~02I", ""},
		'{"~01X", ""},
		'{"~01T3D", "?01"},
		'{"~01T3C", "!01"},
		'{"~01I", "!01"},
		'{"%0101000700", "!01"},
		'{"%0101000700", "?01"},
		'{"~01I", "!01"},
		'{"~010", "!0100"},
		'{"%0101000700", "?01"},
		'{"~01T00", "!01"},
		'{"~01O7013N", "!01"},
		'{"$01M", "!017013N"},
		'{"~01OABCDEF", "!01"},
		'{"$01M", "!01ABCDEF"},
		'{"~013164", "!01"},
		'{"~012", "!01164"},
		'{"~010", "!0180"},
		'{"~**", ""},
		'{"~01300A", "!01"},
		'{"~012", "!0100A"}
	};

	always #25 core_clk = ~core_clk;
	// Nonvolatile store keeps the flag; it must not follow the cleared flop during reset
	always @(posedge core_clk) if (!reset) nv_store <= nv_flag;
	always @(posedge core_clk) if (config_apply === 1'b1) applies++;

	sihw_decoder #(.TICK_CYCLES_P(10)) dut (.core_clk_in(core_clk), .reset_in(reset),
		.rx_data_in(rx_data), .rx_valid_in(rx_valid), .rx_error_in(rx_error),
		.tx_data_out(tx_data), .tx_valid_out(tx_valid), .tx_ready_in(tx_ready),
		.nv_flag_in(nv_store), .nv_flag_out(nv_flag), .config_apply_out(config_apply),
		.config_data_out(config_data), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
		.hwrite_in(hwrite), .hsize_in(3'b010), .hwdata_in(hwdata), .hready_in(hreadyout),
		.hreadyout_out(hreadyout), .hresp_out(hresp), .hrdata_out(hrdata));
	sihw_host_model host (.clk_in(core_clk), .tx_data_in(tx_data), .tx_valid_in(tx_valid),
		.rx_data_out(rx_data), .rx_valid_out(rx_valid), .rx_error_out(rx_error),
		.tx_ready_out(tx_ready));

	task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: word %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic check_reply(input string exp);
		total_checks++;
		if (host.got != exp) begin
			mismatches++;
			$display("mismatch at %0t: reply %s, expected %s", $time, host.got, exp);
		end
	endtask
	// Sends one frame and waits a bounded time for the whole reply
	task automatic run(input string cmd, input string rep, input bit err);
		string exp;
		exp = (rep.len() == 0) ? "" : {rep, "\r"};
		host.send(cmd, err);
		for (int n = 0; n < 60 && host.got.len() < exp.len(); n++)
			@(posedge core_clk);
		repeat (6) @(posedge core_clk);
		check_reply(exp);
	endtask
	// Single word transfer: address phase, then data phase, each held until hready
	task automatic ahb(input logic [7:0] a, input logic wr, input logic [31:0] wd,
		output logic [31:0] rdv);
		@(posedge core_clk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h000000, a};
		hwrite <= wr;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		rdv = hrdata;
	endtask
	task automatic conclude();
		$display("checks %0d, mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	initial begin
		repeat (3) @(posedge core_clk);
		reset <= 1'b0;
		@(posedge core_clk);
		foreach (rows[i]) run(rows[i].cmd, rows[i].rep, 1'b0);
		check_word(32'(applies), 32'h00000001);
		check_word(config_data, 32'h01000700);
		run("~010", "", 1'b1);
		host.slow = 1'b1;
		run("~013105", "!01", 1'b0);
		repeat (6) run("~**", "", 1'b0);
		run("~010", "!0180", 1'b0);
		repeat (100) @(posedge core_clk);
		run("~010", "!0104", 1'b0);
		run("~012", "!01005", 1'b0);
		check_word({31'h0, nv_flag}, 32'h00000001);
		host.slow = 1'b0;
		run("~01T01", "!01", 1'b0);
		run("~01I", "!01", 1'b0);
		repeat (150) @(posedge core_clk);
		run("%0101000700", "?01", 1'b0);
		// Reset in mid-run: the flag must come back from the store
		reset <= 1'b1;
		repeat (3) @(posedge core_clk);
		reset <= 1'b0;
		repeat (2) @(posedge core_clk);
		ahb(REG_STATUS, 1'b0, 32'h00000000, rd);
		check_word(rd, 32'h00000004);
		run("~010", "!0104", 1'b0);
		run("~01I", "?01", 1'b0);
		run("~011", "!01", 1'b0);
		run("~010", "!0100", 1'b0);
		ahb(REG_CTRL, 1'b1, 32'h00000205, rd);
		run("%0501000700", "!05", 1'b0);
		ahb(REG_CONFIG, 1'b0, 32'h00000000, rd);
		check_word(rd, 32'h01000700);
		ahb(8'h40, 1'b0, 32'h00000000, rd);
		check_word(rd, 32'h00000000);
		ahb(REG_CTRL, 1'b0, 32'h00000000, rd);
		check_word(rd, 32'h00000205);
		check_word({31'h0, hresp}, 32'h00000000);
		check_word(32'(applies), 32'h00000002);
		// Checksum on: frames carry their sum, replies carry their own
		ahb(REG_CTRL, 1'b1, 32'h00000105, rd);
		run("~05013", "!0500E6", 1'b0);
		run("~05014", "", 1'b0);
		conclude();
	end
	// Whole run needs under two thousand cycles; this limit leaves ample margin
	initial begin
		repeat (20000) @(posedge core_clk);
		mismatches++;
		$display("mismatch at %0t: run did not finish in time", $time);
		conclude();
	end
endmodule // test_soft_init_host_watchdog_cmds
